/* wmw_window_watchdog.v */
// window watchdog: window sequence, error counter, reset and power-down counters, apb registers
//
// What this block does
// - open-window service subtracts step, failure adds step
// - timing config write adds error, restarts sequence
// - six-bit error counter, steps from step register
// - sequence is closed phase then open phase
// - reset, service, timing write or expiry restart
// - sequence loops forever, halts on reset/abnormal
// - timing loadable by register or service data
// - early service or missing service is error
// - early and timeout flags kept, not read-cleared
// - received flag, cleared by read or timeout
// - every check failure reported to total counter
// - heartbeat timer paces pass and total increments
// - counter overflows drive reset, shutoff, pins; only error counter overflow drives power-down
// - two group reads return packed status words
// - sample command captures heartbeat timer and prediv
// - general and per-source watchdog reset cause flags
// - option bits: can, lin, reset enable, question
// - reset counter +1 per overflow, stops full/disabled/during reset pulse
// - error counter overflow advances window power-down count
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "wmw_defs.vh"

module wmw_window_watchdog #(
    parameter [15:0] TICK_CYCLES = `WMW_TICK_US * `WMW_CLK_MHZ
) (
    input  wire        clk,
    input  wire        reset,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        normal_op_in,
    input  wire        functional_error_in,
    input  wire        functional_pass_overflow_in,
    input  wire        total_error_overflow_in,
    output reg  [5:0]  window_error_count,
    output reg         window_error_overflow,
    output reg         check_fail,
    output reg         heartbeat_event,
    output reg         watchdog_reset,
    output reg         safe_state_can_mode,
    output reg         safe_state_lin_mode,
    output reg         question_pattern_select,
    output reg         keep_question_enable,
    input  wire        reset_pin_in,
    output reg         reset_pin_out,
    output reg         reset_pin_oe_n,
    input  wire        monitor_pin_in,
    output reg         monitor_pin_out,
    output reg         monitor_pin_oe_n
);

    localparam [1:0] ST_CLOSED = 2'b01;
    localparam [1:0] ST_OPEN   = 2'b10;
    localparam integer OPRST_I = `WMW_OPRST_NS / `WMW_CLK_NS;
    localparam [8:0] OPRST_CYC = OPRST_I[8:0];

    // address compare used by the write and read-clear decodes
    function hit;
        input [7:0] a;
        input [7:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    // two-stage synchronisers for the asynchronous pin inputs
    wire [2:0] pin_raw = {monitor_pin_in, reset_pin_in, normal_op_in};
    reg  [2:0] sync1_ff;
    reg  [2:0] sync2_ff;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clk) begin
                if (reset) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate
    wire normal_op_s = sync2_ff[0];

    // window time base
    wire tick;
    wmw_tick_div #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .clk     (clk),
        .reset   (reset),
        .tick_ff (tick)
    );

    // state registers
    reg  [1:0]  st_ff;
    reg  [3:0]  wcnt_ff;
    reg  [7:0]  timing_ff;
    reg  [7:0]  step_ff;
    reg  [4:0]  opt_ff;
    reg  [6:0]  hbp_ff;
    reg  [5:0]  wec_ff;
    reg         too_early_ff;
    reg         timeout_ff;
    reg         svc_rcvd_ff;
    reg  [7:0]  prediv_ff;
    reg  [6:0]  hbt_ff;
    reg  [6:0]  hbs_timer_ff;
    reg  [7:0]  hbs_prediv_ff;
    reg  [2:0]  reset_count_ff;
    reg  [2:0]  wpd_ff;
    reg         shutoff_ff;
    reg         wdrst_ff;
    reg  [8:0]  wdrst_cnt_ff;
    reg         cause_win_ff;
    reg         cause_fun_ff;
    reg         cause_tec_ff;
    reg         wd_caused_ff;

    // monitoring-module reset: global reset or own watchdog reset pulse
    wire mon_rst = reset | wdrst_ff;
    wire halt    = mon_rst | ~normal_op_s;

    // apb phases: writes and read side effects at the access edge
    wire setup  = psel & ~penable;
    wire acc    = psel & penable & pready;
    wire wr     = acc & pwrite;
    wire rd     = acc & ~pwrite;

    wire wr_timing = wr & hit(paddr, `WMW_A_TIMING);
    wire wr_step   = wr & hit(paddr, `WMW_A_STEP);
    wire wr_svc    = wr & hit(paddr, `WMW_A_SERVICE) & ~halt;
    wire wr_opt    = wr & hit(paddr, `WMW_A_OPTIONS);
    wire wr_hbp    = wr & hit(paddr, `WMW_A_HBCFG) & (pwdata[6:0] != 7'h00);
    wire wr_cmd    = wr & hit(paddr, `WMW_A_COMMAND);
    wire rd_stat_a = rd & (hit(paddr, `WMW_A_STAT_A) | hit(paddr, `WMW_A_GROUP_A)
                         | hit(paddr, `WMW_A_GROUP_B));

    // window phase ends on the tick that reaches the programmed length
    wire [3:0] cur_len   = (st_ff == ST_CLOSED) ? timing_ff[7:4] : timing_ff[3:0];
    wire       phase_end = tick & (wcnt_ff == cur_len);
    wire open_expire = ~halt & (st_ff == ST_OPEN) & phase_end;
    wire svc_early   = wr_svc & (st_ff == ST_CLOSED);
    wire svc_pass    = wr_svc & (st_ff == ST_OPEN);
    wire win_err     = svc_early | open_expire;
    wire restart     = wr_svc | (wr_timing & ~halt) | open_expire;

    // closed then open phase, counted in ticks
    always @(posedge clk) begin
        if (halt | restart) begin
            st_ff   <= ST_CLOSED;
            wcnt_ff <= 4'h0;
        end else if (tick) begin
            if (wcnt_ff == cur_len) begin
                wcnt_ff <= 4'h0;
                case (st_ff)
                    ST_CLOSED: begin
                        st_ff <= ST_OPEN;
                    end
                    ST_OPEN: begin
                        st_ff <= ST_CLOSED;
                    end
                    default: begin
                        st_ff <= ST_CLOSED;
                    end
                endcase
            end else begin
                wcnt_ff <= wcnt_ff + 4'h1;
            end
        end
    end

    // window timing from register write or service command payload
    always @(posedge clk) begin
        if (mon_rst) begin
            timing_ff <= `WMW_TIMING_RST;
        end else if (wr_timing) begin
            timing_ff <= pwdata[7:0];
        end else if (wr_svc & pwdata[`WMW_F_SVC_LOAD]) begin
            timing_ff <= pwdata[7:0];
        end
    end

    // plain configuration registers
    always @(posedge clk) begin
        if (reset) begin
            step_ff <= `WMW_STEP_RST;
            opt_ff  <= `WMW_OPT_RST;
        end else begin
            if (wr_step) begin
                step_ff <= pwdata[7:0];
            end
            if (wr_opt) begin
                opt_ff <= pwdata[4:0];
            end
        end
    end

    // error counter next value, saturating, with overflow detect
    wire       wec_up  = win_err | (wr_timing & ~halt);
    wire [6:0] wec_sum = {1'b0, wec_ff} + {3'b000, step_ff[3:0]};
    wire       wec_ovf = wec_up & (wec_sum > {1'b0, `WMW_WEC_MAX});
    reg  [5:0] nxt_wec;
    always @* begin
        nxt_wec = wec_ff;
        if (wec_up) begin
            nxt_wec = wec_ovf ? `WMW_WEC_MAX : wec_sum[5:0];
        end else if (svc_pass) begin
            if (wec_ff > {2'b00, step_ff[7:4]}) begin
                nxt_wec = wec_ff - {2'b00, step_ff[7:4]};
            end else begin
                nxt_wec = 6'h00;
            end
        end
    end

    always @(posedge clk) begin
        if (mon_rst) begin
            wec_ff <= 6'h00;
        end else begin
            wec_ff <= nxt_wec;
        end
    end

    // diagnosis of the last sequence and service-received status
    always @(posedge clk) begin
        if (reset) begin
            too_early_ff <= 1'b0;
            timeout_ff   <= 1'b0;
            svc_rcvd_ff  <= 1'b0;
        end else begin
            if (wr_svc | open_expire) begin
                too_early_ff <= svc_early;
                timeout_ff   <= open_expire;
            end
            if (wr_svc) begin
                svc_rcvd_ff <= 1'b1;
            end else if (rd_stat_a | open_expire) begin
                svc_rcvd_ff <= 1'b0;
            end
        end
    end

    // heartbeat prescaler and period timer with sample capture
    wire       pre_wrap = tick & (prediv_ff == `WMW_HB_PREDIV - 8'h01);
    wire [6:0] hbt_inc  = hbt_ff + 7'h01;
    wire       hb_early = wr_hbp & (pwdata[6:0] <= hbt_ff);
    wire       hb_fire  = ~halt & (hb_early | (pre_wrap & (hbt_inc >= hbp_ff)));
    always @(posedge clk) begin
        if (mon_rst) begin
            prediv_ff <= 8'h00;
            hbt_ff    <= 7'h00;
            hbp_ff    <= `WMW_HBP_RST;
        end else begin
            if (wr_hbp) begin
                hbp_ff <= pwdata[6:0];
            end
            if (tick) begin
                prediv_ff <= pre_wrap ? 8'h00 : prediv_ff + 8'h01;
            end
            if (hb_fire) begin
                hbt_ff <= 7'h00;
            end else if (pre_wrap) begin
                hbt_ff <= hbt_inc;
            end
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            hbs_timer_ff  <= 7'h00;
            hbs_prediv_ff <= 8'h00;
        end else if (wr_cmd & pwdata[`WMW_F_CMD_HBS]) begin
            hbs_timer_ff  <= hbt_ff;
            hbs_prediv_ff <= prediv_ff;
        end
    end

    // reset counter, power-down counter, shutoff start and reset pulse
    wire ovf_any  = wec_ovf | functional_pass_overflow_in | total_error_overflow_in;
    wire reset_count_adv = ovf_any & opt_ff[`WMW_F_OPT_WATCHDOG_RESET_ENABLE] & (reset_count_ff != `WMW_CNT3_MAX)
                    & ~wdrst_ff;
    always @(posedge clk) begin
        if (reset) begin
            reset_count_ff      <= 3'h0;
            wpd_ff       <= 3'h0;
            shutoff_ff   <= 1'b0;
            wdrst_ff     <= 1'b0;
            wdrst_cnt_ff <= 9'h000;
            cause_win_ff <= 1'b0;
            cause_fun_ff <= 1'b0;
            cause_tec_ff <= 1'b0;
            wd_caused_ff <= 1'b0;
        end else begin
            if (reset_count_adv) begin
                reset_count_ff      <= reset_count_ff + 3'h1;
                wdrst_ff     <= 1'b1;
                wdrst_cnt_ff <= OPRST_CYC - 9'h001;
                wd_caused_ff <= 1'b1;
                cause_win_ff <= cause_win_ff | wec_ovf;
                cause_fun_ff <= cause_fun_ff | functional_pass_overflow_in;
                cause_tec_ff <= cause_tec_ff | total_error_overflow_in;
                if (reset_count_ff == `WMW_CNT3_MAX - 3'h1) begin
                    shutoff_ff <= 1'b1;
                end
            end else if (wdrst_ff) begin
                if (wdrst_cnt_ff == 9'h000) begin
                    wdrst_ff <= 1'b0;
                end else begin
                    wdrst_cnt_ff <= wdrst_cnt_ff - 9'h001;
                end
            end
            if (wec_ovf & (wpd_ff != `WMW_CNT3_MAX)) begin
                wpd_ff <= wpd_ff + 3'h1;
            end
        end
    end

    // registered outputs toward neighbour units and pins
    always @(posedge clk) begin
        if (reset) begin
            window_error_count      <= 6'h00;
            window_error_overflow   <= 1'b0;
            check_fail              <= 1'b0;
            heartbeat_event         <= 1'b0;
            watchdog_reset          <= 1'b0;
            safe_state_can_mode     <= 1'b0;
            safe_state_lin_mode     <= 1'b0;
            question_pattern_select <= 1'b0;
            keep_question_enable    <= 1'b0;
            reset_pin_out           <= 1'b0;
            reset_pin_oe_n          <= 1'b1;
            monitor_pin_out         <= 1'b0;
            monitor_pin_oe_n        <= 1'b1;
        end else begin
            window_error_count      <= mon_rst ? 6'h00 : nxt_wec;
            window_error_overflow   <= wec_ovf;
            check_fail              <= win_err | functional_error_in;
            heartbeat_event         <= hb_fire;
            watchdog_reset          <= reset_count_adv | (wdrst_ff & (wdrst_cnt_ff != 9'h000));
            safe_state_can_mode     <= opt_ff[`WMW_F_OPT_CAN];
            safe_state_lin_mode     <= opt_ff[`WMW_F_OPT_LIN];
            question_pattern_select <= opt_ff[`WMW_F_OPT_QPAT];
            keep_question_enable    <= opt_ff[`WMW_F_OPT_KEEPQ];
            reset_pin_out           <= 1'b0;
            reset_pin_oe_n          <= ~(reset_count_adv | (wdrst_ff & (wdrst_cnt_ff != 9'h000)));
            monitor_pin_out         <= 1'b0;
            monitor_pin_oe_n        <= ~(reset_count_adv | shutoff_ff
                                         | (wdrst_ff & (wdrst_cnt_ff != 9'h000)));
        end
    end

    // packed status words
    wire [7:0] stat_a = {svc_rcvd_ff, shutoff_ff, wpd_ff, reset_count_ff};
    wire [7:0] stat_b = {5'h00, wdrst_ff, sync2_ff[2], sync2_ff[1]};
    wire [7:0] diag   = {3'h0, cause_tec_ff, cause_fun_ff, cause_win_ff, timeout_ff,
                         too_early_ff};

    // read mux and decode
    reg [31:0] rmux;
    reg        rmiss;
    always @* begin
        rmux  = 32'h00000000;
        rmiss = 1'b0;
        case (paddr)
            `WMW_A_TIMING:   rmux = {24'h000000, timing_ff};
            `WMW_A_STEP:     rmux = {24'h000000, step_ff};
            `WMW_A_SERVICE:  rmux = 32'h00000000;
            `WMW_A_OPTIONS:  rmux = {27'h0000000, opt_ff};
            `WMW_A_HBCFG:    rmux = {25'h0000000, hbp_ff};
            `WMW_A_STAT_A:   rmux = {24'h000000, stat_a};
            `WMW_A_STAT_B:   rmux = {24'h000000, stat_b};
            `WMW_A_DIAG:     rmux = {24'h000000, diag};
            `WMW_A_WEC:      rmux = {26'h0000000, wec_ff};
            `WMW_A_OPSTAT_B: rmux = {31'h00000000, wd_caused_ff};
            `WMW_A_COMMAND:  rmux = 32'h00000000;
            `WMW_A_HBSAMPLE: rmux = {16'h0000, hbs_prediv_ff, 1'b0, hbs_timer_ff};
            `WMW_A_GROUP_A:  rmux = {timing_ff, 2'b00, wec_ff, diag, stat_a};
            `WMW_A_GROUP_B:  rmux = {prediv_ff, 1'b0, hbt_ff, stat_b, stat_a};
            default:         rmiss = 1'b1;
        endcase
    end

    // apb slave: answer prepared in setup, one access cycle
    always @(posedge clk) begin
        if (reset) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup & rmiss;
            if (setup & ~pwrite) begin
                prdata <= rmiss ? 32'h00000000 : rmux;
            end
        end
    end

endmodule // wmw_window_watchdog

/* wmw_defs.vh */
// register offsets, field positions, reset values and timing counts of the window watchdog
`ifndef WMW_DEFS_VH
`define WMW_DEFS_VH

// apb byte addresses
`define WMW_A_TIMING     8'h00
`define WMW_A_STEP       8'h04
`define WMW_A_SERVICE    8'h08
`define WMW_A_OPTIONS    8'h0c
`define WMW_A_HBCFG      8'h10
`define WMW_A_STAT_A     8'h14
`define WMW_A_STAT_B     8'h18
`define WMW_A_DIAG       8'h1c
`define WMW_A_WEC        8'h20
`define WMW_A_OPSTAT_B   8'h24
`define WMW_A_COMMAND    8'h28
`define WMW_A_HBSAMPLE   8'h2c
`define WMW_A_GROUP_A    8'h30
`define WMW_A_GROUP_B    8'h34

// field positions
`define WMW_F_SVC_LOAD   8
`define WMW_F_OPT_CAN    0
`define WMW_F_OPT_LIN    1
`define WMW_F_OPT_WATCHDOG_RESET_ENABLE  2
`define WMW_F_OPT_QPAT   3
`define WMW_F_OPT_KEEPQ  4
`define WMW_F_CMD_HBS    0

// reset values
`define WMW_TIMING_RST   8'h33
`define WMW_STEP_RST     8'h11
`define WMW_OPT_RST      5'h04
`define WMW_HBP_RST      7'h0a

// counter limits
`define WMW_WEC_MAX      6'h3f
`define WMW_CNT3_MAX     3'h7

// timing
`define WMW_CLK_MHZ      200
`define WMW_CLK_NS       5
`define WMW_TICK_US      100
`define WMW_OPRST_NS     2000
`define WMW_HB_PREDIV    8'h0a

`endif

/* wmw_tick_div.v */
// prescaler giving the one-cycle window tick enable
`timescale 1ns/1ps

module wmw_tick_div #(
    parameter [15:0] CYCLES = 16'h4e20
) (
    input  wire clk,
    input  wire reset,
    output reg  tick_ff
);

    localparam [15:0] LAST = CYCLES - 16'h0001;

    reg  [15:0] cnt_ff;
    wire        wrap = (cnt_ff == LAST);

    // free running count, pulse on wrap
    always @(posedge clk) begin
        if (reset) begin
            cnt_ff  <= 16'h0000;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= wrap ? 16'h0000 : cnt_ff + 16'h0001;
            tick_ff <= wrap;
        end
    end

endmodule // wmw_tick_div

/* wmw_monitor.sv */
// checker of apb handshake, window counter and reset pin behaviour
`timescale 1ns/1ps

module wmw_monitor #(
    parameter [15:0] TICK_CYCLES = 16'h0004
) (
    input logic       clk,
    input logic       reset,
    input logic       psel,
    input logic       penable,
    input logic       pwrite,
    input logic [7:0] paddr,
    input logic       pready,
    input logic       pslverr,
    input logic       functional_error_in,
    input logic [5:0] window_error_count,
    input logic       window_error_overflow,
    input logic       check_fail,
    input logic       watchdog_reset,
    input logic       reset_pin_out,
    input logic       reset_pin_oe_n,
    input logic       monitor_pin_out,
    input logic       monitor_pin_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    logic setup_ff;
    // remembers a setup cycle so the access phase can be tied to it
    always @(posedge clk) begin
        setup_ff <= psel && !penable && !reset;
    end

    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable && setup_ff;
    endproperty
    property p_unmapped;
        pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h34);
    endproperty
    property p_cfg_inc;
        psel && penable && pready && pwrite && paddr == 8'h00 && !watchdog_reset
            && window_error_count < 6'h30 |=> window_error_count > $past(window_error_count);
    endproperty
    property p_ovf_full;
        window_error_overflow |-> window_error_count == 6'h3f;
    endproperty
    property p_pin_drive;
        $rose(watchdog_reset) |-> ##[0:2] (!reset_pin_oe_n && !monitor_pin_oe_n);
    endproperty
    property p_pulse_len;
        $rose(watchdog_reset) |-> watchdog_reset [*8];
    endproperty
    property p_open_drain;
        reset_pin_out == 1'b0 && monitor_pin_out == 1'b0;
    endproperty
    property p_release;
        $fell(reset) |-> window_error_count == 6'h00 && reset_pin_oe_n;
    endproperty
    property p_func_fail;
        functional_error_in |-> ##[1:2] check_fail;
    endproperty

    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no pready after setup");
    a_ready_in_access: assert property (p_ready_in_access) else $error("stray pready");
    a_unmapped: assert property (p_unmapped) else $error("pslverr wrong for address");
    a_cfg_inc: assert property (p_cfg_inc) else $error("timing write kept count");
    a_ovf_full: assert property (p_ovf_full) else $error("overflow below full");
    a_pin_drive: assert property (p_pin_drive) else $error("pins not pulled low");
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    a_release: assert property (p_release) else $error("bad state after reset");
    a_func_fail: assert property (p_func_fail) else $error("failure not reported");

    c_overflow: cover property (window_error_overflow);
    c_wd_reset: cover property ($rose(watchdog_reset));
    c_fail: cover property (check_fail && !functional_error_in);
endmodule // wmw_monitor

bind wmw_window_watchdog wmw_monitor #(.TICK_CYCLES(TICK_CYCLES)) wmw_monitor_inst (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .functional_error_in(functional_error_in), .window_error_count(window_error_count),
    .window_error_overflow(window_error_overflow), .check_fail(check_fail),
    .watchdog_reset(watchdog_reset), .reset_pin_out(reset_pin_out),
    .reset_pin_oe_n(reset_pin_oe_n), .monitor_pin_out(monitor_pin_out),
    .monitor_pin_oe_n(monitor_pin_oe_n)
);

/* wmw_host_model.sv */
// apb master standing in for the supervised microcontroller
`timescale 1ns/1ps

module wmw_host_model (
    input  logic        clk,
    input  logic        reset,
    input  logic        start,
    input  logic        wr,
    input  logic [7:0]  addr,
    input  logic [31:0] wdata,
    output logic        done_ff,
    output logic [31:0] rdata_ff,
    output logic        err_ff,
    output logic        psel,
    output logic        penable,
    output logic        pwrite,
    output logic [7:0]  paddr,
    output logic [31:0] pwdata,
    input  logic [31:0] prdata,
    input  logic        pready,
    input  logic        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata, done_ff} = '0;

    // setup, then access held until pready; service data may carry new timing
    always @(posedge clk) begin
        done_ff <= 1'b0;
        if (reset) begin
            psel <= 1'b0;
            penable <= 1'b0;
        end else if (start && !psel) begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end else if (psel && !penable) begin
            penable <= 1'b1;
        end else if (psel && pready) begin
            rdata_ff <= prdata;
            err_ff <= pslverr;
            done_ff <= 1'b1;
            psel <= 1'b0;
            penable <= 1'b0;
            paddr <= ~paddr; // released lines do not keep their value
            pwdata <= ~pwdata;
        end
    end
endmodule // wmw_host_model

/* test_window_monitor_watchdog.sv */
// self-checking bench of the window watchdog driven through the host model
`timescale 1ns/1ps
`include "wmw_defs.vh"

module test_window_monitor_watchdog;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        start = 1'b0;
    logic        wr = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        fe_in = 1'b0;
    logic        done, err, psel, penable, pwrite, pready, pslverr;
    logic        wovf, cfail, hb, wdr, can_m, lin_m, qps, kqe, rpo, rpoe, mpo, mpoe;
    logic [7:0]  paddr;
    logic [5:0]  wec;
    logic [31:0] pwdata, prdata, rdata, rd, w;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #2.5 clk = ~clk;

    wmw_window_watchdog #(.TICK_CYCLES(16'h0004)) wmw_window_watchdog_inst (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .normal_op_in(1'b1), .functional_error_in(fe_in),
        .functional_pass_overflow_in(1'b0), .total_error_overflow_in(1'b0),
        .window_error_count(wec), .window_error_overflow(wovf), .check_fail(cfail),
        .heartbeat_event(hb), .watchdog_reset(wdr), .safe_state_can_mode(can_m),
        .safe_state_lin_mode(lin_m), .question_pattern_select(qps),
        .keep_question_enable(kqe), .reset_pin_in(rpoe ? 1'b1 : rpo),
        .reset_pin_out(rpo), .reset_pin_oe_n(rpoe), .monitor_pin_in(mpoe ? 1'b1 : mpo),
        .monitor_pin_out(mpo), .monitor_pin_oe_n(mpoe)
    );

    wmw_host_model wmw_host_model_inst (
        .clk(clk), .reset(reset), .start(start), .wr(wr), .addr(addr), .wdata(wdata),
        .done_ff(done), .rdata_ff(rdata), .err_ff(err), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr)
    );

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one transfer through the host model, bounded wait for its completion
    task apb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        start <= 1'b1;
        wr <= w_en;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h0, 32'h1);
        rd = rdata;
    endtask

    task automatic wait_hi(ref logic s, input int lim);
        int n;
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask

    task t_reset_values;
        apb(0, `WMW_A_TIMING, 0);
        chk(rd, 32'h33);
        apb(0, `WMW_A_STEP, 0);
        chk(rd, 32'h11);
        apb(0, `WMW_A_STAT_B, 0);
        chk({30'h0, rd[1:0]}, 32'h3);
        apb(0, 8'h40, 0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1, `WMW_A_OPTIONS, 32'h1f);
        repeat (2) @(negedge clk);
        chk({28'h0, can_m, lin_m, qps, kqe}, 32'hf);
    endtask

    // service in the closed window right after a restart
    task t_early;
        apb(1, `WMW_A_TIMING, 32'h33);
        apb(0, `WMW_A_WEC, 0);
        w = rd;
        apb(1, `WMW_A_SERVICE, 32'h0);
        apb(0, `WMW_A_WEC, 0);
        chk(rd, w + 1);
        apb(0, `WMW_A_DIAG, 0);
        chk({31'h0, rd[0]}, 32'h1);
        apb(0, `WMW_A_DIAG, 0);
        chk({31'h0, rd[0]}, 32'h1);
    endtask

    task t_open;
        apb(1, `WMW_A_STEP, 32'h21);
        apb(1, `WMW_A_TIMING, 32'h0f);
        apb(0, `WMW_A_WEC, 0);
        w = rd;
        repeat (10) @(negedge clk);
        apb(1, `WMW_A_SERVICE, 32'h0);
        apb(0, `WMW_A_WEC, 0);
        chk(rd, (w >= 2) ? w - 2 : 32'h0);
        apb(0, `WMW_A_STAT_A, 0);
        chk({31'h0, rd[7]}, 32'h1);
        apb(0, `WMW_A_STAT_A, 0);
        chk({31'h0, rd[7]}, 32'h0);
        apb(0, `WMW_A_DIAG, 0);
        chk({30'h0, rd[1:0]}, 32'h0);
    endtask

    // shortest windows with no service, then timing loaded by service data
    task t_timeout;
        apb(1, `WMW_A_TIMING, 32'h00);
        wait_hi(cfail, 40);
        chk({31'h0, cfail}, 32'h1);
        apb(0, `WMW_A_DIAG, 0);
        chk({30'h0, rd[1:0]}, 32'h2);
        apb(1, `WMW_A_SERVICE, 32'h1a5);
        apb(0, `WMW_A_TIMING, 0);
        chk(rd, 32'ha5);
        apb(1, `WMW_A_TIMING, 32'hff);
    endtask

    task t_func;
        @(posedge clk);
        fe_in <= 1'b1;
        @(posedge clk);
        fe_in <= 1'b0;
        wait_hi(cfail, 4);
        chk({31'h0, cfail}, 32'h1);
        apb(1, `WMW_A_HBCFG, 32'h1);
        wait_hi(hb, 60);
        chk({31'h0, hb}, 32'h1);
    endtask

    // timing writes push the counter past full scale
    task t_overflow;
        int n;
        apb(1, `WMW_A_STEP, 32'h0f);
        apb(0, `WMW_A_WEC, 0);
        w = rd;
        while (w + 15 <= 63) begin
            apb(1, `WMW_A_TIMING, 32'hff);
            w = w + 15;
        end
        apb(1, `WMW_A_TIMING, 32'hff);
        wait_hi(wdr, 10);
        chk({31'h0, wdr}, 32'h1);
        chk({30'h0, rpoe, mpoe}, 32'h0);
        apb(0, `WMW_A_STAT_A, 0);
        chk({26'h0, rd[5:0]}, 32'h09);
        apb(0, `WMW_A_DIAG, 0);
        chk({31'h0, rd[2]}, 32'h1);
        apb(0, `WMW_A_OPSTAT_B, 0);
        chk({31'h0, rd[0]}, 32'h1);
        n = 0;
        while (wdr !== 1'b0 && n < 500) begin
            @(negedge clk);
            n++;
        end
        apb(0, `WMW_A_WEC, 0);
        chk(rd, 32'h0);
        apb(0, `WMW_A_TIMING, 0);
        chk(rd, 32'h33);
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_reset_values;
        t_early;
        t_open;
        t_timeout;
        t_func;
        t_overflow;
        print_verdict;
    end

    // cuts a hang short
    initial begin
        #50000;
        chk(32'h0, 32'h1);
        print_verdict;
    end
endmodule // test_window_monitor_watchdog
